/* File: hw/iis_addr_gen.sv */
// indexed address generator: base + displacement + scaled index
`timescale 1ns/1ps
module iis_addr_gen (
	input  logic                      base_from_pc,
	input  logic [31:0]               base_addr_reg,
	input  logic [31:0]               pc_value,
	input  iis_pkg::iis_index_type    index_src,
	input  logic [31:0]               index_data_reg,
	input  logic [31:0]               index_addr_reg,
	input  logic [1:0]                scale_sel,
	input  logic [31:0]               displacement,
	output logic [31:0]               eff_addr
);
	logic [31:0] base_pointer;
	logic [31:0] index_operand;
	logic [31:0] scaled_index;

	// base is either an address register or the program counter
	assign base_pointer = base_from_pc ? pc_value : base_addr_reg; // RULE13

	// index from data reg, address reg, or suppressed to zero
	always_comb
	begin
		unique case (index_src)
			iis_pkg::IIS_INDEX_DATA: index_operand = index_data_reg; // RULE12
			iis_pkg::IIS_INDEX_ADDR: index_operand = index_addr_reg; // RULE12
			default:                 index_operand = 32'h0000_0000; // RULE12
		endcase
	end

	// scale by 1, 2 or 4; code 3 is not a legal scale and falls back to 1
	always_comb
	begin
		unique case (scale_sel)
			2'd1:    scaled_index = {index_operand[30:0], 1'b0}; // RULE11
			2'd2:    scaled_index = {index_operand[29:0], 2'b00}; // RULE11
			default: scaled_index = index_operand; // RULE11
		endcase
	end

	// displacement arrives already sign-widened to 32 bits
	assign eff_addr = base_pointer + displacement + scaled_index;
endmodule // iis_addr_gen

/* File: hw/iis_cond_eval.sv */
// condition evaluator over the four flags C, V, Z, N for conditional branches
`timescale 1ns/1ps
module iis_cond_eval (
	input  logic [3:0] cond_sel,
	input  logic [7:0] flag_byte,
	output logic       cond_true
);
	logic c;
	logic v;
	logic z;
	logic n;

	// flags pulled from their positions in the flag byte
	assign c = flag_byte[iis_pkg::FLAG_C_POS];
	assign v = flag_byte[iis_pkg::FLAG_V_POS];
	assign z = flag_byte[iis_pkg::FLAG_Z_POS];
	assign n = flag_byte[iis_pkg::FLAG_N_POS];

	// customary sixteen condition codes; code 1 acts as never-true here
	always_comb
	begin
		unique case (cond_sel)
			4'h0: cond_true = 1'b1;
			4'h1: cond_true = 1'b0;
			4'h2: cond_true = ~c & ~z;
			4'h3: cond_true = c | z;
			4'h4: cond_true = ~c;
			4'h5: cond_true = c;
			4'h6: cond_true = ~z;
			4'h7: cond_true = z;
			4'h8: cond_true = ~v;
			4'h9: cond_true = v;
			4'hA: cond_true = ~n;
			4'hB: cond_true = n;
			4'hC: cond_true = ~(n ^ v);
			4'hD: cond_true = n ^ v;
			4'hE: cond_true = ~z & ~(n ^ v);
			4'hF: cond_true = z | (n ^ v);
		endcase
	end
endmodule // iis_cond_eval

/* File: hw/iis_core.sv */
// integer execution core: register files, flags, program counter, one op per cycle
// Notes on behaviour
// RULE1: register and pointer sums add source into destination
// RULE2: immediate and quick sums add immediate
// RULE3: immediate AND into a data register
// RULE4: xor data register into destination
// RULE5: immediate xor into a data register
// RULE6: conditional branch adds displacement only if true
// RULE7: subroutine branch pushes next pc, then jumps
// RULE8: immediate compare sets flags, no writeback
// RULE9: sign widen replicates top bit upward
// RULE10: byte, word, long signed operand sizes
// RULE11: index scaled by one, two or four
// RULE12: index from address, data, or suppressed
// RULE13: base from address register or pc
// RULE14: flag byte is low byte of state word
// RULE15: five flags updated by math, read by branches
// RULE16: displacement width set by instruction form
// RULE17: compare sets NZVC, keeps extend
// RULE18: long add sets carry extend overflow negative zero
`timescale 1ns/1ps
module iis_core (
	input  logic                   core_clk,
	input  logic                   rst,
	input  logic                   op_valid,
	input  iis_pkg::iis_op_type    op_code,
	input  iis_pkg::iis_size_type  op_size,
	input  logic [2:0]             dst_idx,
	input  logic [2:0]             src_idx,
	input  logic                   src_is_addr,
	input  logic [31:0]            imm_value,
	input  logic [3:0]             cond_sel,
	input  logic [15:0]            disp_value,
	input  logic                   base_from_pc,
	input  iis_pkg::iis_index_type index_src,
	input  logic [2:0]             index_idx,
	input  logic [1:0]             scale_sel,
	input  logic                   state_word_wr,
	input  logic [15:0]            state_word_wdata,
	input  logic                   flag_byte_wr,
	input  logic [7:0]             flag_byte_wdata,
	output logic [31:0]            pc_out,
	output logic [15:0]            state_word_out,
	output logic [7:0]             flag_byte_out,
	output logic [31:0]            eff_addr_out,
	output logic                   stack_wr_valid,
	output logic [31:0]            stack_wr_addr,
	output logic [31:0]            stack_wr_data,
	output logic [31:0]            dst_data_out,
	output logic [31:0]            dst_addr_out
);
	logic [31:0] data_reg_n [iis_pkg::NUM_REGS];
	logic [31:0] address_reg_n [iis_pkg::NUM_REGS];
	logic [31:0] pc_reg;
	logic [15:0] state_word_reg;
	logic [31:0] eff_addr_reg;
	logic        stack_wr_valid_reg;
	logic [31:0] stack_wr_addr_reg;
	logic [31:0] stack_wr_data_reg;
	logic [31:0] dst_data_reg;
	logic [31:0] dst_addr_reg;

	logic [31:0] src_operand;
	logic [31:0] dst_operand;
	logic [31:0] sum_b;
	logic [32:0] sum_full;
	logic [32:0] diff_full;
	logic [31:0] xor_res;
	logic [31:0] and_res;
	logic [31:0] widen_res;
	logic [31:0] disp_ext;
	logic [31:0] sp_next;
	logic [31:0] next_pc;
	logic        cond_true;
	logic [31:0] eff_addr;
	logic [7:0]  flag_byte;
	logic [7:0]  flag_next;
	logic        flag_upd;

	// sign-widen a value of the given size to a longword
	function automatic logic [31:0] widen_to_long(input logic [31:0] v, input iis_pkg::iis_size_type sz);
		logic [31:0] r;
		r = v;
		unique case (sz)
			iis_pkg::IIS_SIZE_BYTE: r = {{24{v[7]}}, v[7:0]}; // RULE10
			iis_pkg::IIS_SIZE_WORD: r = {{16{v[15]}}, v[15:0]}; // RULE10
			default:                r = v;
		endcase
		return r;
	endfunction

	// flag byte is a view of the low byte of the state word
	assign flag_byte      = state_word_reg[7:0]; // RULE14
	assign flag_byte_out  = flag_byte;
	assign state_word_out = state_word_reg;
	assign pc_out         = pc_reg;
	assign eff_addr_out   = eff_addr_reg;
	assign stack_wr_valid = stack_wr_valid_reg;
	assign stack_wr_addr  = stack_wr_addr_reg;
	assign stack_wr_data  = stack_wr_data_reg;
	assign dst_data_out   = dst_data_reg;
	assign dst_addr_out   = dst_addr_reg;

	// operand fetch; source may be either register class
	assign src_operand = src_is_addr ? address_reg_n[src_idx] : data_reg_n[src_idx];
	assign dst_operand = (op_code == iis_pkg::IIS_OP_POINTER_SUM) ? address_reg_n[dst_idx] : data_reg_n[dst_idx];

	// immediate forms add the immediate, others the source register
	always_comb
	begin
		unique case (op_code)
			iis_pkg::IIS_OP_IMMEDIATE_SUM,
			iis_pkg::IIS_OP_QUICK_SUM: sum_b = imm_value; // RULE2
			default:                   sum_b = src_operand; // RULE1
		endcase
	end

	assign sum_full  = {1'b0, dst_operand} + {1'b0, sum_b}; // RULE1
	assign diff_full = {1'b0, data_reg_n[dst_idx]} - {1'b0, imm_value}; // RULE8
	assign and_res   = imm_value & data_reg_n[dst_idx]; // RULE3
	assign xor_res   = ((op_code == iis_pkg::IIS_OP_IMM_XOR) ? imm_value : src_operand) ^ data_reg_n[dst_idx]; // RULE4 RULE5

	// byte form widens straight to long; word form widens byte to word, long form word to long
	always_comb
	begin
		widen_res = data_reg_n[dst_idx];
		if (op_code == iis_pkg::IIS_OP_BYTE_SIGN_WIDEN)
			widen_res = widen_to_long(data_reg_n[dst_idx], iis_pkg::IIS_SIZE_BYTE); // RULE9
		else if (op_size == iis_pkg::IIS_SIZE_WORD)
			widen_res = {data_reg_n[dst_idx][31:16], {8{data_reg_n[dst_idx][7]}}, data_reg_n[dst_idx][7:0]}; // RULE9
		else
			widen_res = widen_to_long(data_reg_n[dst_idx], iis_pkg::IIS_SIZE_WORD); // RULE9
	end

	// displacement is 8 or 16 bits wide depending on the form
	assign disp_ext = (op_size == iis_pkg::IIS_SIZE_BYTE) ? widen_to_long({16'h0000, disp_value}, iis_pkg::IIS_SIZE_BYTE)
		: widen_to_long({16'h0000, disp_value}, iis_pkg::IIS_SIZE_WORD); // RULE16
	assign sp_next  = address_reg_n[iis_pkg::SP_INDEX] - iis_pkg::STACK_STEP; // RULE7
	assign next_pc  = pc_reg + iis_pkg::NEXT_PC_STEP;

	iis_cond_eval u_cond (
		.cond_sel  (cond_sel),
		.flag_byte (flag_byte),
		.cond_true (cond_true)
	);

	iis_addr_gen u_addr (
		.base_from_pc   (base_from_pc),
		.base_addr_reg  (address_reg_n[src_idx]),
		.pc_value       (pc_reg),
		.index_src      (index_src),
		.index_data_reg (data_reg_n[index_idx]),
		.index_addr_reg (address_reg_n[index_idx]),
		.scale_sel      (scale_sel),
		.displacement   (disp_ext),
		.eff_addr       (eff_addr)
	);

	// flag computation; logic ops clear V and C, keep X
	always_comb
	begin
		flag_next = flag_byte;
		flag_upd  = 1'b0;
		unique case (op_code)
			iis_pkg::IIS_OP_REG_SUM, iis_pkg::IIS_OP_IMMEDIATE_SUM, iis_pkg::IIS_OP_QUICK_SUM:
			begin
				flag_upd                      = 1'b1;
				flag_next[iis_pkg::FLAG_C_POS] = sum_full[32]; // RULE18
				flag_next[iis_pkg::FLAG_X_POS] = sum_full[32]; // RULE18
				flag_next[iis_pkg::FLAG_V_POS] = (dst_operand[31] == sum_b[31]) & (sum_full[31] != sum_b[31]); // RULE18
				flag_next[iis_pkg::FLAG_N_POS] = sum_full[31]; // RULE18
				flag_next[iis_pkg::FLAG_Z_POS] = (sum_full[31:0] == 32'h0000_0000); // RULE18
			end
			iis_pkg::IIS_OP_IMM_COMPARE:
			begin
				flag_upd                      = 1'b1;
				flag_next[iis_pkg::FLAG_C_POS] = diff_full[32]; // RULE17
				flag_next[iis_pkg::FLAG_V_POS] = (data_reg_n[dst_idx][31] != imm_value[31])
					& (diff_full[31] != data_reg_n[dst_idx][31]); // RULE17
				flag_next[iis_pkg::FLAG_N_POS] = diff_full[31]; // RULE17
				flag_next[iis_pkg::FLAG_Z_POS] = (diff_full[31:0] == 32'h0000_0000); // RULE17
			end
			iis_pkg::IIS_OP_IMM_CONJ, iis_pkg::IIS_OP_EXCL_OR, iis_pkg::IIS_OP_IMM_XOR,
			iis_pkg::IIS_OP_SIGN_WIDEN, iis_pkg::IIS_OP_BYTE_SIGN_WIDEN:
			begin
				flag_upd                      = 1'b1;
				flag_next[iis_pkg::FLAG_C_POS] = 1'b0;
				flag_next[iis_pkg::FLAG_V_POS] = 1'b0;
				flag_next[iis_pkg::FLAG_N_POS] = (op_code == iis_pkg::IIS_OP_IMM_CONJ) ? and_res[31]
					: ((op_code == iis_pkg::IIS_OP_SIGN_WIDEN) || (op_code == iis_pkg::IIS_OP_BYTE_SIGN_WIDEN)) ? widen_res[31]
					: xor_res[31];
				flag_next[iis_pkg::FLAG_Z_POS] = (op_code == iis_pkg::IIS_OP_IMM_CONJ) ? (and_res == 32'h0000_0000)
					: ((op_code == iis_pkg::IIS_OP_SIGN_WIDEN) || (op_code == iis_pkg::IIS_OP_BYTE_SIGN_WIDEN))
					? (widen_res == 32'h0000_0000) : (xor_res == 32'h0000_0000);
			end
			default:
				flag_upd = 1'b0;
		endcase
	end

	// state word: op flag updates win over a software write in the same cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_word_reg <= iis_pkg::STATE_WORD_RST;
		else if (op_valid && flag_upd)
			state_word_reg[7:0] <= flag_next; // RULE15
		else if (state_word_wr)
			state_word_reg <= state_word_wdata; // RULE14
		else if (flag_byte_wr)
			state_word_reg[7:0] <= flag_byte_wdata; // RULE14
	end

	// data registers: one generate slot per register
	genvar gi;
	generate
		for (gi = 0; gi < iis_pkg::NUM_REGS; gi++)
		begin : g_data
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					data_reg_n[gi] <= 32'h0000_0000;
				else if (op_valid && dst_idx == gi)
				begin
					unique case (op_code)
						iis_pkg::IIS_OP_REG_SUM, iis_pkg::IIS_OP_IMMEDIATE_SUM,
						iis_pkg::IIS_OP_QUICK_SUM:    data_reg_n[gi] <= sum_full[31:0]; // RULE1 RULE2
						iis_pkg::IIS_OP_IMM_CONJ:     data_reg_n[gi] <= and_res; // RULE3
						iis_pkg::IIS_OP_EXCL_OR,
						iis_pkg::IIS_OP_IMM_XOR:      data_reg_n[gi] <= xor_res; // RULE4 RULE5
						iis_pkg::IIS_OP_SIGN_WIDEN,
						iis_pkg::IIS_OP_BYTE_SIGN_WIDEN: data_reg_n[gi] <= widen_res; // RULE9
						default:                      data_reg_n[gi] <= data_reg_n[gi]; // RULE8
					endcase
				end
			end
		end
	endgenerate

	// address registers; slot 7 doubles as stack pointer
	generate
		for (gi = 0; gi < iis_pkg::NUM_REGS; gi++)
		begin : g_addr
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					address_reg_n[gi] <= (gi == iis_pkg::SP_INDEX) ? iis_pkg::SP_RST : 32'h0000_0000;
				else if (op_valid && op_code == iis_pkg::IIS_OP_POINTER_SUM && dst_idx == gi)
					address_reg_n[gi] <= sum_full[31:0]; // RULE1
				else if (op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH && gi == iis_pkg::SP_INDEX)
					address_reg_n[gi] <= sp_next; // RULE7
			end
		end
	endgenerate

	// program counter: sequential unless a branch is taken
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pc_reg <= iis_pkg::PC_RST;
		else if (op_valid)
		begin
			if (op_code == iis_pkg::IIS_OP_SUB_BRANCH)
				pc_reg <= pc_reg + disp_ext; // RULE7
			else if (op_code == iis_pkg::IIS_OP_COND_BRANCH && cond_true)
				pc_reg <= pc_reg + disp_ext; // RULE6
			else
				pc_reg <= next_pc; // RULE6
		end
	end

	// stack store request: return address at the new stack top, one-cycle pulse
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stack_wr_valid_reg <= 1'b0;
			stack_wr_addr_reg  <= 32'h0000_0000;
			stack_wr_data_reg  <= 32'h0000_0000;
		end
		else
		begin
			stack_wr_valid_reg <= op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH; // RULE7
			if (op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH)
			begin
				stack_wr_addr_reg <= sp_next; // RULE7
				stack_wr_data_reg <= next_pc; // RULE7
			end
		end
	end

	// effective address and register observation outputs
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			eff_addr_reg <= 32'h0000_0000;
			dst_data_reg <= 32'h0000_0000;
			dst_addr_reg <= 32'h0000_0000;
		end
		else
		begin
			if (op_valid && op_code == iis_pkg::IIS_OP_ADDR_CALC)
				eff_addr_reg <= eff_addr; // RULE11 RULE13
			dst_data_reg <= data_reg_n[dst_idx];
			dst_addr_reg <= address_reg_n[dst_idx];
		end
	end

	// checks on results the rules fix, not on the wiring that makes them
	chk_cmp_no_write: assert property (@(posedge core_clk) disable iff (rst) // RULE8
		op_valid && op_code == iis_pkg::IIS_OP_IMM_COMPARE
		|=> data_reg_n[$past(dst_idx)] == $past(data_reg_n[dst_idx]))
		else $error("compare changed its register");
	chk_cmp_keeps_x: assert property (@(posedge core_clk) disable iff (rst) // RULE17
		op_valid && op_code == iis_pkg::IIS_OP_IMM_COMPARE |=> $stable(flag_byte[iis_pkg::FLAG_X_POS]))
		else $error("compare changed extend flag");
	chk_branch_not_taken: assert property (@(posedge core_clk) disable iff (rst) // RULE6
		op_valid && op_code == iis_pkg::IIS_OP_COND_BRANCH && !cond_true |=> pc_reg == $past(pc_reg) + 32'h0000_0002)
		else $error("untaken branch moved pc wrongly");
	chk_branch_taken: assert property (@(posedge core_clk) disable iff (rst) // RULE6
		op_valid && op_code == iis_pkg::IIS_OP_COND_BRANCH && cond_true |=> pc_reg == $past(pc_reg) + $past(disp_ext))
		else $error("taken branch target wrong");
	chk_sub_branch_push: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH |=> stack_wr_valid
		&& stack_wr_addr == $past(address_reg_n[iis_pkg::SP_INDEX]) - 32'h0000_0004
		&& stack_wr_data == $past(pc_reg) + 32'h0000_0002)
		else $error("subroutine push wrong");
	chk_stack_ptr_step: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH
		|=> address_reg_n[iis_pkg::SP_INDEX] == $past(address_reg_n[iis_pkg::SP_INDEX]) - 32'h0000_0004)
		else $error("stack pointer not lowered by four");
	chk_add_carry: assert property (@(posedge core_clk) disable iff (rst) // RULE18
		op_valid && op_code == iis_pkg::IIS_OP_REG_SUM && !state_word_wr |=>
		flag_byte[iis_pkg::FLAG_C_POS] == flag_byte[iis_pkg::FLAG_X_POS])
		else $error("carry and extend disagree after add");
	chk_flag_view: assert property (@(posedge core_clk) disable iff (rst) // RULE14
		flag_byte_wr && !state_word_wr && !(op_valid && flag_upd)
		|=> state_word_out == {$past(state_word_out[15:8]), $past(flag_byte_wdata)})
		else $error("flag byte write missed the state word");
	chk_xor_result: assert property (@(posedge core_clk) disable iff (rst) // RULE5
		op_valid && op_code == iis_pkg::IIS_OP_IMM_XOR
		|=> data_reg_n[$past(dst_idx)] == ($past(imm_value) ^ $past(data_reg_n[dst_idx])))
		else $error("immediate xor result wrong");
	cov_sub_branch: cover property (@(posedge core_clk) op_valid && op_code == iis_pkg::IIS_OP_SUB_BRANCH);
	cov_taken: cover property (@(posedge core_clk) op_valid && op_code == iis_pkg::IIS_OP_COND_BRANCH && cond_true);
	cov_carry: cover property (@(posedge core_clk) op_valid && op_code == iis_pkg::IIS_OP_REG_SUM && sum_full[32]);
	cov_word_widen: cover property (@(posedge core_clk)
		op_valid && op_code == iis_pkg::IIS_OP_SIGN_WIDEN && op_size == iis_pkg::IIS_SIZE_WORD);
endmodule // iis_core

/* File: hw/iis_pkg.sv */
// package: opcodes, flag positions, widths and constants for the integer execution block
package iis_pkg;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned REG_IDX_W   = 3;
	localparam int unsigned NUM_REGS    = 8;
	// flag positions inside the flag byte
	localparam int unsigned FLAG_C_POS  = 0;
	localparam int unsigned FLAG_V_POS  = 1;
	localparam int unsigned FLAG_Z_POS  = 2;
	localparam int unsigned FLAG_N_POS  = 3;
	localparam int unsigned FLAG_X_POS  = 4;
	// flag byte sits in the low byte of the processor state word
	localparam int unsigned FLAG_BYTE_LSB = 0;
	localparam int unsigned FLAG_BYTE_W   = 8;
	localparam logic [15:0] STATE_WORD_RST = 16'h2700;
	localparam logic [31:0] PC_RST        = 32'h0000_0000;
	localparam logic [31:0] SP_RST        = 32'h0000_0000;
	localparam logic [31:0] STACK_STEP    = 32'h0000_0004;
	localparam logic [31:0] NEXT_PC_STEP  = 32'h0000_0002;
	localparam int unsigned SP_INDEX      = 7;
	localparam int unsigned DISP_W_BYTE   = 8;
	localparam int unsigned DISP_W_WORD   = 16;

	typedef enum logic [3:0] {
		IIS_OP_NOP,
		IIS_OP_REG_SUM,
		IIS_OP_POINTER_SUM,
		IIS_OP_IMMEDIATE_SUM,
		IIS_OP_QUICK_SUM,
		IIS_OP_IMM_CONJ,
		IIS_OP_EXCL_OR,
		IIS_OP_IMM_XOR,
		IIS_OP_IMM_COMPARE,
		IIS_OP_COND_BRANCH,
		IIS_OP_SUB_BRANCH,
		IIS_OP_SIGN_WIDEN,
		IIS_OP_BYTE_SIGN_WIDEN,
		IIS_OP_ADDR_CALC
	} iis_op_type;

	typedef enum logic [1:0] {
		IIS_SIZE_BYTE,
		IIS_SIZE_WORD,
		IIS_SIZE_LONG
	} iis_size_type;

	typedef enum logic [1:0] {
		IIS_INDEX_NONE,
		IIS_INDEX_DATA,
		IIS_INDEX_ADDR
	} iis_index_type;
endpackage

/* File: testbench/integer_instruction_semantics_test.sv */
// self-checking bench for the integer execution core
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module integer_instruction_semantics_test;
	logic                   core_clk;
	logic                   rst;
	logic                   op_valid;
	iis_pkg::iis_op_type    op_code;
	iis_pkg::iis_size_type  op_size;
	logic [2:0]             dst_idx;
	logic [2:0]             src_idx;
	logic                   src_is_addr;
	logic [31:0]            imm_value;
	logic [3:0]             cond_sel;
	logic [15:0]            disp_value;
	logic                   base_from_pc;
	iis_pkg::iis_index_type index_src;
	logic [2:0]             index_idx;
	logic [1:0]             scale_sel;
	logic                   state_word_wr;
	logic [15:0]            state_word_wdata;
	logic                   flag_byte_wr;
	logic [7:0]             flag_byte_wdata;
	logic [31:0]            pc_out;
	logic [15:0]            state_word_out;
	logic [7:0]             flag_byte_out;
	logic [31:0]            eff_addr_out;
	logic                   stack_wr_valid;
	logic [31:0]            stack_wr_addr;
	logic [31:0]            stack_wr_data;
	logic [31:0]            dst_data_out;
	logic [31:0]            dst_addr_out;
	int                     mismatches;
	int                     checks_done;
	int                     push_cnt;
	logic [31:0]            push_addr;
	logic [31:0]            push_data;
	logic [31:0]            exp_pc;

	iis_core DUT (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_size(op_size),
		.dst_idx(dst_idx), .src_idx(src_idx), .src_is_addr(src_is_addr), .imm_value(imm_value),
		.cond_sel(cond_sel), .disp_value(disp_value), .base_from_pc(base_from_pc), .index_src(index_src),
		.index_idx(index_idx), .scale_sel(scale_sel), .state_word_wr(state_word_wr),
		.state_word_wdata(state_word_wdata), .flag_byte_wr(flag_byte_wr), .flag_byte_wdata(flag_byte_wdata),
		.pc_out(pc_out), .state_word_out(state_word_out), .flag_byte_out(flag_byte_out),
		.eff_addr_out(eff_addr_out), .stack_wr_valid(stack_wr_valid), .stack_wr_addr(stack_wr_addr),
		.stack_wr_data(stack_wr_data), .dst_data_out(dst_data_out), .dst_addr_out(dst_addr_out));

	// 200 MHz clock
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	// one op, then idle long enough for the delayed register views; pushes are counted meanwhile
	task automatic op(iis_pkg::iis_op_type c, iis_pkg::iis_size_type s, logic [2:0] d, logic [2:0] sr,
		logic sa, logic [31:0] imm, logic [15:0] disp, logic [3:0] cs);
		@(posedge core_clk);
		op_valid <= 1'b1; op_code <= c; op_size <= s; dst_idx <= d; src_idx <= sr;
		src_is_addr <= sa; imm_value <= imm; disp_value <= disp; cond_sel <= cs;
		@(posedge core_clk);
		op_valid <= 1'b0;
		push_cnt = 0;
		repeat (3)
		begin
			#1;
			if (stack_wr_valid === 1'b1)
			begin
				push_cnt++; push_addr = stack_wr_addr; push_data = stack_wr_data;
			end
			@(posedge core_clk);
		end
		#1;
		// pc holds while no op is offered; branches adjust exp_pc themselves
		if (c != iis_pkg::IIS_OP_COND_BRANCH && c != iis_pkg::IIS_OP_SUB_BRANCH) exp_pc = exp_pc + 32'h0000_0002;
	endtask

	// shorthand for a long-size op without branch fields
	task automatic opl(iis_pkg::iis_op_type c, logic [2:0] d, logic [2:0] sr, logic sa, logic [31:0] imm);
		op(c, iis_pkg::IIS_SIZE_LONG, d, sr, sa, imm, 16'h0000, 4'h0);
	endtask

	task automatic t_reset;
		`CHK(pc_out, 32'h0000_0000)
		`CHK(state_word_out, 16'h2700)
		`CHK(flag_byte_out, 8'h00)
		`CHK(stack_wr_valid, 1'b0)
	endtask

	// carry, overflow and register/pointer sums
	task automatic t_sums;
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h0, 3'h0, 1'b0, 32'hFFFF_FFFF);
		`CHK(dst_data_out, 32'hFFFF_FFFF)
		`CHK(flag_byte_out, 8'h08)
		opl(iis_pkg::IIS_OP_QUICK_SUM, 3'h0, 3'h0, 1'b0, 32'h0000_0001);
		`CHK(dst_data_out, 32'h0000_0000)
		`CHK(flag_byte_out, 8'h15)
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h1, 3'h0, 1'b0, 32'h7FFF_FFFF);
		opl(iis_pkg::IIS_OP_QUICK_SUM, 3'h1, 3'h0, 1'b0, 32'h0000_0001);
		`CHK(dst_data_out, 32'h8000_0000)
		`CHK(flag_byte_out, 8'h0A)
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h2, 3'h0, 1'b0, 32'h0000_0005);
		opl(iis_pkg::IIS_OP_REG_SUM, 3'h2, 3'h1, 1'b0, 32'h0);
		`CHK(dst_data_out, 32'h8000_0005)
		opl(iis_pkg::IIS_OP_POINTER_SUM, 3'h3, 3'h2, 1'b0, 32'h0);
		`CHK(dst_addr_out, 32'h8000_0005)
		opl(iis_pkg::IIS_OP_REG_SUM, 3'h0, 3'h3, 1'b1, 32'h0);
		`CHK(dst_data_out, 32'h8000_0005)
		`CHK(pc_out, exp_pc)
	endtask

	// logic ops, compares and extend-flag retention
	task automatic t_logic;
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h4, 3'h0, 1'b0, 32'hF0F0_1234);
		opl(iis_pkg::IIS_OP_IMM_CONJ, 3'h4, 3'h0, 1'b0, 32'hFF00_FF00);
		`CHK(dst_data_out, 32'hF000_1200)
		`CHK(flag_byte_out, 8'h08)
		opl(iis_pkg::IIS_OP_IMM_XOR, 3'h4, 3'h0, 1'b0, 32'hF000_1200);
		`CHK(dst_data_out, 32'h0000_0000)
		`CHK(flag_byte_out, 8'h04)
		opl(iis_pkg::IIS_OP_EXCL_OR, 3'h4, 3'h2, 1'b0, 32'h0);
		`CHK(dst_data_out, 32'h8000_0005)
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h5, 3'h0, 1'b0, 32'hFFFF_FFFF);
		opl(iis_pkg::IIS_OP_QUICK_SUM, 3'h5, 3'h0, 1'b0, 32'h0000_0001);
		opl(iis_pkg::IIS_OP_IMM_XOR, 3'h5, 3'h0, 1'b0, 32'h8000_0000);
		`CHK(flag_byte_out, 8'h18)
		opl(iis_pkg::IIS_OP_IMM_COMPARE, 3'h5, 3'h0, 1'b0, 32'h8000_0000);
		`CHK(flag_byte_out, 8'h14)
		opl(iis_pkg::IIS_OP_IMM_COMPARE, 3'h5, 3'h0, 1'b0, 32'h0000_0001);
		`CHK(flag_byte_out, 8'h12)
		`CHK(dst_data_out, 32'h8000_0000)
		opl(iis_pkg::IIS_OP_IMM_COMPARE, 3'h7, 3'h0, 1'b0, 32'h0000_0001);
		`CHK(flag_byte_out, 8'h19)
		`CHK(dst_data_out, 32'h0000_0000)
	endtask

	// widen forms; the word form leaves the upper half alone
	task automatic t_widen;
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h6, 3'h0, 1'b0, 32'h1234_5680);
		op(iis_pkg::IIS_OP_SIGN_WIDEN, iis_pkg::IIS_SIZE_WORD, 3'h6, 3'h0, 1'b0, 32'h0, 16'h0, 4'h0);
		`CHK(dst_data_out, 32'h1234_FF80)
		opl(iis_pkg::IIS_OP_SIGN_WIDEN, 3'h6, 3'h0, 1'b0, 32'h0);
		`CHK(dst_data_out, 32'hFFFF_FF80)
		opl(iis_pkg::IIS_OP_IMMEDIATE_SUM, 3'h6, 3'h0, 1'b0, 32'h0000_0100);
		opl(iis_pkg::IIS_OP_BYTE_SIGN_WIDEN, 3'h6, 3'h0, 1'b0, 32'h0);
		`CHK(dst_data_out, 32'hFFFF_FF80)
		`CHK(flag_byte_out, 8'h18)
	endtask

	// software write of one flag pattern through the flag byte view
	task automatic flags_set(logic [7:0] f);
		@(posedge core_clk);
		flag_byte_wr <= 1'b1; flag_byte_wdata <= f;
		@(posedge core_clk);
		flag_byte_wr <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(state_word_out, {8'h27, f})
	endtask

	// taken, not taken, flag-driven and subroutine branches
	task automatic t_branch;
		op(iis_pkg::IIS_OP_COND_BRANCH, iis_pkg::IIS_SIZE_BYTE, 3'h7, 3'h0, 1'b0, 32'h0, 16'h12FE, 4'h0);
		exp_pc = exp_pc - 32'h0000_0002;
		`CHK(pc_out, exp_pc)
		op(iis_pkg::IIS_OP_COND_BRANCH, iis_pkg::IIS_SIZE_WORD, 3'h7, 3'h0, 1'b0, 32'h0, 16'h0100, 4'h1);
		exp_pc = exp_pc + 32'h0000_0002;
		`CHK(pc_out, exp_pc)
		flags_set(8'h04);
		op(iis_pkg::IIS_OP_COND_BRANCH, iis_pkg::IIS_SIZE_WORD, 3'h7, 3'h0, 1'b0, 32'h0, 16'hFF00, 4'h7);
		exp_pc = exp_pc - 32'h0000_0100;
		`CHK(pc_out, exp_pc)
		flags_set(8'h00);
		op(iis_pkg::IIS_OP_COND_BRANCH, iis_pkg::IIS_SIZE_WORD, 3'h7, 3'h0, 1'b0, 32'h0, 16'hFF00, 4'h7);
		exp_pc = exp_pc + 32'h0000_0002;
		`CHK(pc_out, exp_pc)
		op(iis_pkg::IIS_OP_SUB_BRANCH, iis_pkg::IIS_SIZE_WORD, 3'h7, 3'h0, 1'b0, 32'h0, 16'h0040, 4'h0);
		`CHK(push_cnt, 1)
		`CHK(push_addr, 32'hFFFF_FFFC)
		`CHK(push_data, exp_pc + 32'h0000_0002)
		`CHK(dst_addr_out, 32'hFFFF_FFFC)
		exp_pc = exp_pc + 32'h0000_0040;
		`CHK(pc_out, exp_pc)
	endtask

	// base from address register or pc, every index source and scale
	task automatic t_addr;
		logic [31:0] f;
		for (int k = 0; k < 8; k++)
		begin
			f = (k[1:0] == 2'd1) ? 32'h2 : (k[1:0] == 2'd2) ? 32'h4 : 32'h1;
			@(posedge core_clk);
			base_from_pc <= k[2]; scale_sel <= k[1:0]; index_idx <= k[2] ? 3'h3 : 3'h2;
			index_src <= (k == 4) ? iis_pkg::IIS_INDEX_NONE : k[2] ? iis_pkg::IIS_INDEX_ADDR : iis_pkg::IIS_INDEX_DATA;
			op(iis_pkg::IIS_OP_ADDR_CALC, iis_pkg::IIS_SIZE_LONG, 3'h0, 3'h3, 1'b1, 32'h0, 16'h0010, 4'h0);
			`CHK(eff_addr_out, (k[2] ? exp_pc - 32'h2 : 32'h8000_0005) + 32'h10 + (k == 4 ? 32'h0 : 32'h8000_0005 * f))
		end
	endtask

	// the state word write shows through the flag byte view
	task automatic t_state;
		@(posedge core_clk);
		state_word_wr <= 1'b1; state_word_wdata <= 16'h2715;
		@(posedge core_clk);
		state_word_wr <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(state_word_out, 16'h2715)
		`CHK(flag_byte_out, 8'h15)
		// an idle op only steps the pc and leaves the flags alone
		opl(iis_pkg::IIS_OP_NOP, 3'h0, 3'h0, 1'b0, 32'h0);
		`CHK(pc_out, exp_pc)
		`CHK(flag_byte_out, 8'h15)
	endtask

	task automatic end_sim;
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#50000;
		mismatches++;
		end_sim();
	end

	initial
	begin
		mismatches = 0; checks_done = 0; exp_pc = 32'h0; push_cnt = 0; push_addr = 32'h0; push_data = 32'h0;
		rst = 1'b1; op_valid = 1'b0; op_code = iis_pkg::IIS_OP_NOP; op_size = iis_pkg::IIS_SIZE_LONG;
		dst_idx = 3'h0; src_idx = 3'h0; src_is_addr = 1'b0; imm_value = 32'h0; cond_sel = 4'h0;
		disp_value = 16'h0; base_from_pc = 1'b0; index_src = iis_pkg::IIS_INDEX_NONE; index_idx = 3'h0;
		scale_sel = 2'h0; state_word_wr = 1'b0; state_word_wdata = 16'h0; flag_byte_wr = 1'b0;
		flag_byte_wdata = 8'h0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_sums();
		t_logic();
		t_widen();
		t_branch();
		t_addr();
		t_state();
		end_sim();
	end
endmodule // integer_instruction_semantics_test
